// file: rtl/timer_b_map.vh
// Purpose: Register map, field positions and constants of the timer group.
// Assumes: 32-bit AXI4-Lite data, byte addresses, one aligned word per register.
// Notes:   Channel n (0 to 2) sits at 0x10 * (n + 1).
`ifndef TIMER_B_MAP_VH
`define TIMER_B_MAP_VH
`define ADDR_W       8
`define DATA_W       32
`define NCH          3
`define CNT_W        16
`define PH_W         6
`define OFF_START    8'h00
`define OFF_INV_CTRL 8'h04
`define OFF_SPECIAL  8'h08
`define OFF_PHASE    8'h0c
`define SUB_MODE     4'h0
`define SUB_CNT      4'h4
`define SUB_IRQ      4'h8
`define TOP_HI       7
`define TOP_LO       6
`define CHF_HI       5
`define CHF_LO       4
`define SUB_HI       3
`define SUB_LO       0
`define MB_OP_HI     1
`define MB_OP_LO     0
`define MB_MEAS0     2
`define MB_MEAS1     3
`define MB_MEAS2     4
`define MB_OVF       5
`define MB_SRC_HI    7
`define MB_SRC_LO    6
`define OP_TIMER     2'h0
`define OP_EVENT     2'h1
`define OP_MEASURE   2'h2
`define EDGE_FALL    2'h0
`define EDGE_RISE    2'h1
`define SRC_DIV1     2'h0
`define SRC_DIV8     2'h1
`define SRC_DIV32    2'h2
`define PRE_W        11
`define PRE_MASK8    11'h007
`define PRE_MASK32   11'h01f
`define PRE_MASK2K   11'h7ff
`define CNT_ONES     16'hffff
`define CNT_ZERO     16'h0000
`define CNT_ONE      16'h0001
`define BIT_TPOE     0
`define BIT_CUTEN    0
`define BIT_TRIPPED  1
`define BIT_IRQ      0
`define BIT_SD_STAT  8
`define MODE_RST     8'h00
`define START_RST    3'h0
`define PHASE_RST    6'h00
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`endif

// file: rtl/timer_b_channel.v
// Purpose: One 16-bit timer channel: timer, event counter and measurement modes.
// Assumes: tick is a one-cycle pulse of the selected count source.
// Notes:   meas_pin is taken as synchronous to ref_clk.
`timescale 1ns/1ps
`include "timer_b_map.vh"
module timer_b_channel (
  input  wire              ref_clk,
  input  wire              sys_rst,
  input  wire              start,
  input  wire [7:0]        mode,
  input  wire              tick,
  input  wire              meas_pin,
  input  wire              wr_cnt,
  input  wire [15:0]       wr_val,
  input  wire              ovf_clr,
  input  wire              irq_clr,
  output wire [15:0]       rd_val,
  output reg               ovf_flag,
  output reg               irq_flag
);
  reg  [15:0] counter;
  reg  [15:0] reload;
  reg         pin_q;
  reg         first_seen;
  reg         tick_after_ovf;
  wire [1:0]  op   = mode[`MB_OP_HI:`MB_OP_LO];
  wire [1:0]  esel = {mode[`MB_MEAS1], mode[`MB_MEAS0]};
  wire        rise = meas_pin & ~pin_q;
  wire        fall = ~meas_pin & pin_q;
  wire        sel_edge = (esel == `EDGE_FALL) ? fall :
                         (esel == `EDGE_RISE) ? rise : (rise | fall);
  wire        measure = (op == `OP_MEASURE);
  wire        cnt_tick = (op == `OP_EVENT) ? sel_edge : tick;
  wire        reload_now = start & ~measure & cnt_tick & (counter == `CNT_ZERO);
  wire        meas_edge = start & measure & sel_edge;
  wire        ovf_set = start & measure & ~sel_edge & tick & (counter == `CNT_ONES);
  wire        irq_set = reload_now | ovf_set | (meas_edge & first_seen);

  // A read that meets a reload sees all ones; measurement reads the captured value.
  assign rd_val = measure ? reload : (reload_now ? `CNT_ONES : counter);

  ////////////////////////////////////////////////////////////////////////////
  // Counting.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      counter    <= `CNT_ZERO;
      reload     <= `CNT_ZERO;
      pin_q      <= 1'b0;
      first_seen <= 1'b0;
    end else begin
      pin_q <= meas_pin;
      if (!start)
        first_seen <= 1'b0;
      if (wr_cnt) begin
        reload <= wr_val;
        if (!start)
          counter <= wr_val;
      end
      if (reload_now) begin
        counter <= reload;
      end else if (start & ~measure & cnt_tick) begin
        counter <= counter - `CNT_ONE;
      end else if (meas_edge) begin
        reload     <= counter;
        counter    <= `CNT_ZERO;
        first_seen <= 1'b1;
      end else if (start & measure & tick) begin
        counter <= counter + `CNT_ONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flags; a set in the same cycle as a clear wins.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ovf_flag       <= 1'b0;
      tick_after_ovf <= 1'b0;
      irq_flag       <= 1'b0;
    end else begin
      if (ovf_set) begin
        ovf_flag       <= 1'b1;
        tick_after_ovf <= 1'b0;
      end else begin
        if (ovf_flag & start & tick)
          tick_after_ovf <= 1'b1;
        if (ovf_clr & start & tick_after_ovf)
          ovf_flag <= 1'b0;
      end
      if (irq_set)
        irq_flag <= 1'b1;
      else if (irq_clr)
        irq_flag <= 1'b0;
    end
  end
endmodule

// file: rtl/timer_b_measure_and_cutoff.v
// Purpose: Three-channel 16-bit timer group with forced three-phase output cutoff.
// Assumes: AXI4-Lite slave, one write and one read outstanding at most.
// Notes:   Phase outputs are released (enable high) whenever output is disabled.
`timescale 1ns/1ps
`include "timer_b_map.vh"
module timer_b_measure_and_cutoff (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [2:0]  meas_pin,
  input  wire        shutdown_input_n,
  output reg  [5:0]  phase_out,
  output reg  [5:0]  phase_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers.

  // True when the address lands in one of the three channel windows.
  function is_chan;
    input [7:0] a;
    begin
      is_chan = (a[`TOP_HI:`TOP_LO] == 2'h0) && (a[`CHF_HI:`CHF_LO] != 2'h0);
    end
  endfunction

  // Channel index of a channel-window address.
  function [1:0] chan_of;
    input [7:0] a;
    begin
      chan_of = a[`CHF_HI:`CHF_LO] - 2'h1;
    end
  endfunction

  // Merges the two low byte lanes of a write into a 16-bit value.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0]  s;
    begin
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // Count-source pulse chosen by the source-select field.
  function pick_tick;
    input [1:0]  sel;
    input [10:0] pre;
    begin
      case (sel)
        `SRC_DIV1:  pick_tick = 1'b1;
        `SRC_DIV8:  pick_tick = ((pre & `PRE_MASK8) == `PRE_MASK8);
        `SRC_DIV32: pick_tick = ((pre & `PRE_MASK32) == `PRE_MASK32);
        default:    pick_tick = (pre == `PRE_MASK2K);
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.
  reg  [7:0]  aw_addr;
  reg         aw_got;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         w_got;
  reg  [7:0]  ar_addr;
  reg         rd_pend;
  reg  [2:0]  start;
  reg  [7:0]  mode [0:2];
  reg         tpoe;
  reg         cut_en;
  reg         tripped;
  reg  [5:0]  phase_level;
  reg  [10:0] prescale;
  reg         next_tpoe;
  reg         next_tripped;
  reg  [2:0]  wr_cnt;
  reg  [2:0]  ovf_clr;
  reg  [2:0]  irq_clr;
  reg         wr_hit;
  reg  [31:0] rd_word;
  reg         rd_hit;
  wire [15:0] rd_val [0:2];
  wire [2:0]  ovf_flag;
  wire [2:0]  irq_flag;
  wire        do_wr = aw_got & w_got & ~s_axi_bvalid;
  wire [1:0]  wch   = chan_of(aw_addr);
  wire [1:0]  rch   = chan_of(ar_addr);
  wire [3:0]  wsub  = aw_addr[`SUB_HI:`SUB_LO];
  wire [3:0]  rsub  = ar_addr[`SUB_HI:`SUB_LO];
  wire        sd_low = ~shutdown_input_n;
  wire        cut_cond = cut_en & ~tripped & tpoe & sd_low;

  ////////////////////////////////////////////////////////////////////////////
  // Channels.
  genvar g;
  generate
    for (g = 0; g < `NCH; g = g + 1) begin : chan
      timer_b_channel u_chan (
        .ref_clk  (ref_clk),
        .sys_rst  (sys_rst),
        .start    (start[g]),
        .mode     (mode[g]),
        .tick     (pick_tick(mode[g][`MB_SRC_HI:`MB_SRC_LO], prescale)),
        .meas_pin (meas_pin[g]),
        .wr_cnt   (wr_cnt[g]),
        .wr_val   (merge16(rd_val[g], w_data, w_strb)),
        .ovf_clr  (ovf_clr[g]),
        .irq_clr  (irq_clr[g]),
        .rd_val   (rd_val[g]),
        .ovf_flag (ovf_flag[g]),
        .irq_flag (irq_flag[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write decode and per-channel strobes.
  always @* begin
    wr_cnt  = 3'h0;
    ovf_clr = 3'h0;
    irq_clr = 3'h0;
    wr_hit  = 1'b0;
    if (is_chan(aw_addr)) begin
      case (wsub)
        `SUB_MODE: wr_hit = 1'b1;
        `SUB_CNT: begin
          wr_hit      = 1'b1;
          wr_cnt[wch] = do_wr;
        end
        `SUB_IRQ: begin
          wr_hit       = 1'b1;
          irq_clr[wch] = do_wr & w_strb[0] & ~w_data[`BIT_IRQ];
        end
        default: wr_hit = 1'b0;
      endcase
      // While running only an overflow clear with MB_MEAS2 written 0 and the other fields unchanged acts.
      if (wsub == `SUB_MODE && start[wch] && w_strb[0] && !w_data[`MB_OVF] &&
          !w_data[`MB_MEAS2] &&
          w_data[`MB_SRC_HI:`MB_SRC_LO] == mode[wch][`MB_SRC_HI:`MB_SRC_LO] &&
          w_data[`MB_MEAS1:`MB_OP_LO] == mode[wch][`MB_MEAS1:`MB_OP_LO])
        ovf_clr[wch] = do_wr;
    end else begin
      case (aw_addr)
        `OFF_START:    wr_hit = 1'b1;
        `OFF_INV_CTRL: wr_hit = 1'b1;
        `OFF_SPECIAL:  wr_hit = 1'b1;
        `OFF_PHASE:    wr_hit = 1'b1;
        default:       wr_hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output enable and cutoff.
  always @* begin
    next_tpoe    = tpoe;
    next_tripped = tripped;
    if (do_wr && aw_addr == `OFF_INV_CTRL && w_strb[0]) begin
      if (!(w_data[`BIT_TPOE] && sd_low))
        next_tpoe = w_data[`BIT_TPOE];
    end
    if (do_wr && aw_addr == `OFF_SPECIAL && w_strb[0] && !w_data[`BIT_CUTEN])
      next_tripped = 1'b0;
    if (cut_cond) begin
      next_tpoe    = 1'b0;
      next_tripped = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software-visible registers.
  integer i;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      start       <= `START_RST;
      tpoe        <= 1'b0;
      cut_en      <= 1'b0;
      tripped     <= 1'b0;
      phase_level <= `PHASE_RST;
      prescale    <= {`PRE_W{1'b0}};
      phase_out   <= `PHASE_RST;
      phase_oe_n  <= {`PH_W{1'b1}};
      for (i = 0; i < `NCH; i = i + 1)
        mode[i] <= `MODE_RST;
    end else begin
      prescale   <= prescale + {{(`PRE_W - 1){1'b0}}, 1'b1};
      tpoe       <= next_tpoe;
      tripped    <= next_tripped;
      phase_out  <= phase_level;
      phase_oe_n <= {`PH_W{~next_tpoe}};
      if (do_wr && w_strb[0]) begin
        case (aw_addr)
          `OFF_START:   start <= w_data[`NCH-1:0];
          `OFF_SPECIAL: cut_en <= w_data[`BIT_CUTEN];
          `OFF_PHASE:   phase_level <= w_data[`PH_W-1:0];
          default:      start <= start;
        endcase
        if (is_chan(aw_addr) && wsub == `SUB_MODE && !start[wch])
          mode[wch] <= w_data[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end else if (!aw_got && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end else if (!w_got && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (do_wr) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read decode.
  always @* begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b1;
    if (is_chan(ar_addr)) begin
      case (rsub)
        `SUB_MODE: begin
          rd_word[7:0]       = mode[rch];
          rd_word[`MB_OVF]   = ovf_flag[rch];
        end
        `SUB_CNT:  rd_word[`CNT_W-1:0] = rd_val[rch];
        `SUB_IRQ:  rd_word[`BIT_IRQ] = irq_flag[rch];
        default:   rd_hit = 1'b0;
      endcase
    end else begin
      case (ar_addr)
        `OFF_START:    rd_word[`NCH-1:0] = start;
        `OFF_INV_CTRL: rd_word[`BIT_TPOE] = tpoe;
        `OFF_SPECIAL: begin
          rd_word[`BIT_CUTEN]   = cut_en;
          rd_word[`BIT_TRIPPED] = tripped;
        end
        `OFF_PHASE: begin
          rd_word[`PH_W-1:0]    = phase_level;
          rd_word[`BIT_SD_STAT] = shutdown_input_n;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channels.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
      ar_addr       <= 8'h00;
      rd_pend       <= 1'b0;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        ar_addr       <= s_axi_araddr;
        rd_pend       <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (!rd_pend && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
      if (rd_pend) begin
        rd_pend      <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// file: tb/timer_b_monitor.sv
// Purpose: Checker of bus answers and phase cutoff at the timer group ports.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
module timer_b_monitor (
  input wire        ref_clk,
  input wire        sys_rst,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        shutdown_input_n,
  input wire [5:0]  phase_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////
  chk_write_answer: assert property (aw_w_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read response late");
  chk_ar_refused: assert property (ar_taken |=> !s_axi_arready)
    else $error("read address taken twice");
  chk_aw_refused: assert property (
    aw_w_taken |=> !s_axi_awready && !s_axi_wready)
    else $error("write taken twice");
  chk_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_oe_uniform: assert property (phase_oe_n == 6'h00 || phase_oe_n == 6'h3f)
    else $error("phase enables split");
  chk_enable_blocked: assert property (
    !shutdown_input_n && phase_oe_n == 6'h3f |=> phase_oe_n == 6'h3f)
    else $error("output enabled during shutdown");
  chk_reset_idle: assert property (
    $fell(sys_rst) |-> phase_oe_n == 6'h3f && !s_axi_bvalid && !s_axi_rvalid)
    else $error("not idle after reset");
endmodule
bind timer_b_measure_and_cutoff timer_b_monitor i_timer_b_monitor (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .shutdown_input_n(shutdown_input_n), .phase_oe_n(phase_oe_n)
);

// file: tb/drive_stage_model.sv
// Purpose: Measured pulse source and motor driver stage.
// Assumes: Pulses and shutdown change right after a rising clock edge.
// Notes:   A released phase line shows the inverse of its last driven level.
`timescale 1ns/1ps
module drive_stage_model #(
  parameter HALF = 16
) (
  input  wire       ref_clk,
  input  wire [2:0] pulse_en,
  input  wire       sd_req,
  input  wire [5:0] phase_out,
  input  wire [5:0] phase_oe_n,
  output reg  [2:0] meas_pin,
  output reg        shutdown_input_n,
  output wire [5:0] phase_line
);
  integer   cnt = 0;
  reg [5:0] last = 6'h00;
  initial begin
    meas_pin = 3'h0;
    shutdown_input_n = 1'b1;
  end
  // Square pulses on enabled channels; shutdown follows the request.
  always @(posedge ref_clk) begin
    cnt <= (cnt == 2 * HALF - 1) ? 0 : cnt + 1;
    meas_pin <= (cnt < HALF) ? 3'h0 : pulse_en;
    shutdown_input_n <= ~sd_req;
    if (phase_oe_n == 6'h00)
      last <= phase_out;
  end
  assign phase_line = (phase_oe_n == 6'h00) ? phase_out : ~last;
endmodule

// file: tb/tb.sv
// Purpose: Self-checking bench of the timer group and its phase cutoff.
// Assumes: AXI4-Lite master tasks; the partner drives pulses and shutdown.
// Notes:   Counts use the divide-by-one source to keep the run short.
`timescale 1ns/1ps
module tb;
  reg         ref_clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, sd_req;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd;
  reg  [2:0]  pulse_en;
  reg  [1:0]  resp;
  wire        awready, wready, bvalid, arready, rvalid, sd_n;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [2:0]  meas_pin;
  wire [5:0]  phase_out, phase_oe_n, phase_line;
  integer     error_cnt, checks_done;
  timer_b_measure_and_cutoff i_timer_b_measure_and_cutoff (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .meas_pin(meas_pin), .shutdown_input_n(sd_n), .phase_out(phase_out),
    .phase_oe_n(phase_oe_n));
  drive_stage_model i_drive_stage_model (
    .ref_clk(ref_clk), .pulse_en(pulse_en), .sd_req(sd_req), .phase_out(phase_out),
    .phase_oe_n(phase_oe_n), .meas_pin(meas_pin), .shutdown_input_n(sd_n),
    .phase_line(phase_line));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////
  task conclude;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task hang;
    begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH wait expected answer seen timeout");
      conclude;
    end
  endtask
  task check(input string nm, input [31:0] exp, input [31:0] got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      while (!(bvalid && bready) && n < 50) begin
        @(posedge ref_clk);
        n = n + 1;
        if (awvalid && awready)
          awvalid <= 1'b0;
        if (wvalid && wready)
          wvalid <= 1'b0;
      end
      resp = bresp;
      bready <= 1'b0;
      if (n >= 50)
        hang;
    end
  endtask
  task rchk(input string nm, input [7:0] a, input [31:0] exp);
    integer n;
    begin
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      while (!(rvalid && rready) && n < 50) begin
        @(posedge ref_clk);
        n = n + 1;
        if (arvalid && arready)
          arvalid <= 1'b0;
      end
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
      if (n >= 50)
        hang;
      if (nm != "")
        check(nm, exp, rd);
    end
  endtask
  task wait_edge;
    integer n;
    begin
      n = 0;
      while (meas_pin[1] !== 1'b0 && n < 99) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      while (meas_pin[1] !== 1'b1 && n < 99) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      if (n >= 99)
        hang;
      repeat (3) @(posedge ref_clk);
    end
  endtask
  ////////////////////////////////////////
  task t_reset;
    begin
      check("oe_n", 32'h3f, {26'h0, phase_oe_n});
      rchk("start", 8'h00, 32'h0);
      rchk("mode2", 8'h30, 32'h0);
      rchk("unmapped", 8'hfc, 32'h0);
      check("rresp", 32'h2, {30'h0, resp});
      wr(8'hfc, 32'h1);
      check("bresp", 32'h2, {30'h0, resp});
    end
  endtask
  task t_timer;
    begin
      wr(8'h10, 32'h0);
      wr(8'h14, 32'h7);
      rchk("cnt0 set", 8'h14, 32'h7);
      repeat (8) @(posedge ref_clk);
      rchk("cnt0 idle", 8'h14, 32'h7);
      wr(8'h00, 32'h1);
      rchk("", 8'h14, 32'h0);
      check("cnt0 live", 32'h1, {31'h0, rd[15:0] < 16'h0007 || rd === 32'hffff});
      rchk("cnt0 reload", 8'h14, 32'hffff);
      rchk("irq0", 8'h18, 32'h1);
      wr(8'h00, 32'h0);
    end
  endtask
  task t_measure;
    begin
      wr(8'h20, 32'h06);
      wr(8'h24, 32'h0);
      wr(8'h00, 32'h2);
      pulse_en <= 3'h2;
      wait_edge;
      rchk("irq1 first", 8'h28, 32'h0);
      wait_edge;
      rchk("irq1 edge", 8'h28, 32'h1);
      rchk("mode1 edge", 8'h20, 32'h06);
      pulse_en <= 3'h0;
      wr(8'h28, 32'h0);
      rchk("irq1 clr", 8'h28, 32'h0);
      wr(8'h00, 32'h0);
      wr(8'h24, 32'hfff0);
      wr(8'h00, 32'h2);
      repeat (40) @(posedge ref_clk);
      rchk("mode1 ovf", 8'h20, 32'h26);
      rchk("irq1 ovf", 8'h28, 32'h1);
      wr(8'h20, 32'h06);
      rchk("ovf clr", 8'h20, 32'h06);
      wr(8'h20, 32'h00);
      rchk("mode1 kept", 8'h20, 32'h06);
      wr(8'h00, 32'h0);
    end
  endtask
  task t_event;
    begin
      wr(8'h10, 32'h05);
      wr(8'h14, 32'h3);
      wr(8'h18, 32'h0);
      wr(8'h00, 32'h1);
      pulse_en <= 3'h1;
      rchk("irq0 early", 8'h18, 32'h0);
      repeat (140) @(posedge ref_clk);
      rchk("irq0 event", 8'h18, 32'h1);
      pulse_en <= 3'h0;
      wr(8'h00, 32'h0);
    end
  endtask
  task t_width;
    begin
      wr(8'h30, 32'h0a);
      wr(8'h00, 32'h4);
      pulse_en <= 3'h4;
      repeat (60) @(posedge ref_clk);
      rchk("width one", 8'h34, 32'h0f);
      repeat (16) @(posedge ref_clk);
      rchk("width two", 8'h34, 32'h0f);
      rchk("irq2 width", 8'h38, 32'h1);
      pulse_en <= 3'h0;
      wr(8'h00, 32'h0);
    end
  endtask
  task t_cutoff;
    begin
      wr(8'h0c, 32'h2a);
      wr(8'h04, 32'h1);
      wr(8'h08, 32'h1);
      check("phase_line", 32'h2a, {26'h0, phase_line});
      sd_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("oe_n cut", 32'h3f, {26'h0, phase_oe_n});
      check("line cut", 32'h15, {26'h0, phase_line});
      rchk("enable cut", 8'h04, 32'h0);
      wr(8'h04, 32'h1);
      rchk("enable held", 8'h04, 32'h0);
      sd_req <= 1'b0;
      repeat (4) @(posedge ref_clk);
      wr(8'h04, 32'h1);
      rchk("enable back", 8'h04, 32'h1);
      check("oe_n back", 32'h0, {26'h0, phase_oe_n});
      wr(8'h08, 32'h0);
      wr(8'h08, 32'h1);
      sd_req <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check("oe_n recut", 32'h3f, {26'h0, phase_oe_n});
      sd_req <= 1'b0;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    sys_rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, sd_req} = 6'h00;
    {awaddr, araddr} = 16'h0000;
    wdata = 32'h0;
    rd = 32'h0;
    pulse_en = 3'h0;
    resp = 2'h0;
    error_cnt = 0;
    checks_done = 0;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    t_reset;
    t_timer;
    t_measure;
    t_event;
    t_width;
    t_cutoff;
    conclude;
  end
endmodule
